// File: core/bbfr_recorder.v
`timescale 1ns/10ps
`include "bbfr_defs.vh"

// Summary of operation
// - eight bytes per record, 250 us each
// - finish whole record before starting another
// - power-on scan picks first flag-one slot
// - slots from F980 to F9F8, eight apart
// - recorder only programs, never erases
// - full region suppresses all further records
// - host polls busy, full and next-slot outputs
// - host erases then resets; search repeats
// - supply undervoltage state may trigger records
// - record holds flag, state, cause, status, checksum
// - each record-state entry while idle and not full starts one record
// - at most sixteen records in region
module bbfr_recorder
#(
    parameter [15:0] BYTE_CYCLES = `BBFR_BYTE_CYCLES
)
(
    input  wire        i_clk,
    input  wire        i_reset,
    input  wire        i_recorder_reset, // host reset, restarts search
    input  wire        i_record_enter,   // pulse: record state entered
    input  wire [3:0]  i_prev_state,     // state exited before entry
    input  wire [1:0]  i_exit_cause,     // sequence, timeout, monitor
    input  wire [15:0] i_uv_ov_status,   // latched comparator status
    input  wire [7:0]  i_gpi_status,     // latched logic input status
    input  wire [7:0]  i_limit_status,   // latched limit status
    output wire [15:0] o_ee_addr,        // eeprom byte address
    output reg  [7:0]  o_ee_wdata,       // byte to program
    output wire        o_ee_read,        // read strobe
    output wire        o_ee_prog,        // program strobe, never erase
    input  wire [7:0]  i_ee_rdata,       // read data, valid next cycle
    output wire        o_busy,           // record or search in progress
    output wire        o_full,           // region exhausted
    output wire [4:0]  o_next_slot       // slot of next record
);

    // the search walks the flag bytes one slot at a time: a read
    // cycle, then a check cycle, since the array answers one clock
    // after the strobe
    // one-hot states
    localparam [4:0] ST_SRD  = 5'b00001; // issue flag read
    localparam [4:0] ST_SCHK = 5'b00010; // check flag
    localparam [4:0] ST_IDLE = 5'b00100; // wait for trigger
    localparam [4:0] ST_PROG = 5'b01000; // start a byte
    localparam [4:0] ST_WAIT = 5'b10000; // wait byte time

    reg  [4:0]  state_reg;
    reg  [4:0]  state_next;
    // the slot counts past the last slot instead of wrapping, so a
    // full region can never overwrite the earliest records
    reg  [4:0]  slot_reg;                // 0..16, 16 means full
    reg  [4:0]  slot_next;
    reg  [2:0]  byte_reg;                // byte index in record
    reg  [2:0]  byte_next;
    reg  [63:0] snap_reg;                // captured record image
    reg  [63:0] snap_next;
    wire        timer_done;              // byte program time over
    wire [7:0]  cur_byte;                // next data byte to program
    wire [7:0]  csum;                    // checksum of bytes 0 to 6

    // slot address: base plus eight bytes per slot
    function [15:0] slot_addr;
        input [4:0] slot;
        input [2:0] idx;
        begin
            // slots never cross a 128-byte boundary, so base plus a
            // plain concatenation is base plus eight bytes per slot
            slot_addr = `BBFR_REGION_BASE
                      + {9'h000, slot[3:0], idx};
        end
    endfunction

    // checksum over the seven data bytes; a record torn by a supply
    // collapse fails it, so a reader can tell it from a whole one
    assign csum = 8'h00 - (snap_reg[7:0] + snap_reg[15:8]
                + snap_reg[23:16] + snap_reg[31:24] + snap_reg[39:32]
                + snap_reg[47:40] + snap_reg[55:48]);

    // byte about to be programmed, taken from the next-state image
    // so byte 0 is ready on the same edge that captures the snapshot
    assign cur_byte = snap_next[{byte_next, 3'b000} +: 8];

    // the timer starts in the strobe cycle itself, so strobes of one
    // record sit BYTE_CYCLES plus one clocks apart
    bbfr_byte_timer #(
        .BYTE_CYCLES (BYTE_CYCLES)
    ) u_timer (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_start (state_reg == ST_PROG),
        .o_busy  (),
        .o_done  (timer_done)
    );

    // next-state logic
    always @*
    begin
        state_next = state_reg;
        slot_next  = slot_reg;
        byte_next  = byte_reg;
        snap_next  = snap_reg;
        case (state_reg)
            ST_SRD:
            begin
                // the read strobe is decoded from this state
                state_next = ST_SCHK;
            end
            ST_SCHK:
            begin
                // erased slot reads flag one: free location found
                if (i_ee_rdata[`BBFR_FLAG_BIT] == `BBFR_FLAG_FREE)
                begin
                    state_next = ST_IDLE;
                end
                else if (slot_reg == `BBFR_SLOT_COUNT - 5'h01)
                begin
                    // none free: mark full until reset
                    slot_next  = `BBFR_SLOT_COUNT;
                    state_next = ST_IDLE;
                end
                else
                begin
                    slot_next  = slot_reg + 5'h01;
                    state_next = ST_SRD;
                end
            end
            ST_IDLE:
            begin
                // triggers while full are dropped; first faults kept
                if (i_record_enter && !slot_reg[4])
                begin
                    // flag byte clears bit 7 to mark slot used
                    snap_next  = {8'h00, i_limit_status, i_gpi_status,
                                  i_uv_ov_status, 14'h0000,
                                  i_exit_cause, 4'h0, i_prev_state};
                    byte_next  = 3'h0;
                    state_next = ST_PROG;
                end
            end
            ST_PROG:
            begin
                // one strobe per byte; there is no erase path at all
                state_next = ST_WAIT;
            end
            ST_WAIT:
            begin
                // new triggers are ignored until the last byte ends
                if (timer_done)
                begin
                    if (byte_reg == 3'h7)
                    begin
                        slot_next  = slot_reg + 5'h01;
                        state_next = ST_IDLE;
                    end
                    else
                    begin
                        byte_next  = byte_reg + 3'h1;
                        state_next = ST_PROG;
                    end
                end
            end
            default:
            begin
                state_next = ST_SRD;
            end
        endcase
    end

    // state registers; host reset restarts the search
    always @(posedge i_clk)
    begin
        if (i_reset || i_recorder_reset)
        begin
            state_reg <= ST_SRD;
            slot_reg  <= 5'h00;
            byte_reg  <= 3'h0;
            snap_reg  <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            slot_reg  <= slot_next;
            byte_reg  <= byte_next;
            snap_reg  <= snap_next;
        end
    end

    // registered write data, loaded as the strobe cycle is entered so
    // it stands for the whole strobe; the last byte is the checksum
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_ee_wdata <= 8'h00;
        end
        else if (state_next == ST_PROG)
        begin
            if (byte_next == 3'h7)
            begin
                // snapshot is stable by now, so the sum is settled
                o_ee_wdata <= csum;
            end
            else
            begin
                o_ee_wdata <= cur_byte;
            end
        end
    end

    assign o_ee_addr   = slot_addr(slot_reg, byte_reg);
    // read strobe is combinational so the flag byte comes back in
    // the check cycle right after it
    assign o_ee_read   = (state_reg == ST_SRD);
    assign o_ee_prog   = (state_reg == ST_PROG);
    assign o_busy      = (state_reg != ST_IDLE);
    assign o_full      = slot_reg[4];
    assign o_next_slot = slot_reg;

endmodule // bbfr_recorder

// File: shared/bbfr_defs.vh
`ifndef BBFR_DEFS_VH
`define BBFR_DEFS_VH

// record region layout
`define BBFR_REGION_BASE    16'hF980
`define BBFR_REGION_LAST    16'hF9F8
`define BBFR_SLOT_BYTES     4'h8
`define BBFR_SLOT_COUNT     5'h10
`define BBFR_SLOT_SHIFT     3

// flag bit position inside byte 0 of a record
`define BBFR_FLAG_BIT       7
// flag value of an erased, unused slot
`define BBFR_FLAG_FREE      1'b1

// timing: 250 us per byte at 50 MHz is 12500 clocks
`define BBFR_BYTE_CYCLES    16'h30d4

// exit cause codes
`define BBFR_CAUSE_SEQ      2'h1
`define BBFR_CAUSE_TMO      2'h2
`define BBFR_CAUSE_MON      2'h3

`endif

// File: core/bbfr_byte_timer.v
`timescale 1ns/10ps
`include "bbfr_defs.vh"

// counts one byte program time after a start pulse
module bbfr_byte_timer
#(
    parameter [15:0] BYTE_CYCLES = `BBFR_BYTE_CYCLES
)
(
    input  wire        i_clk,
    input  wire        i_reset,
    input  wire        i_start,     // one-cycle start pulse
    output wire        o_busy,      // high while the byte is programming
    output wire        o_done       // one-cycle pulse at the end
);

    reg  [15:0] count_reg;          // cycles left, zero when idle
    reg  [15:0] count_next;

    // load on start, count down to zero otherwise
    always @*
    begin
        count_next = count_reg;
        if (i_start)
        begin
            count_next = BYTE_CYCLES;
        end
        else if (count_reg != 16'h0000)
        begin
            count_next = count_reg - 16'h0001;
        end
    end

    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            count_reg <= 16'h0000;
        end
        else
        begin
            count_reg <= count_next;
        end
    end

    assign o_busy = (count_reg != 16'h0000);
    assign o_done = (count_reg == 16'h0001);

endmodule // bbfr_byte_timer

// File: dv/bbfr_eeprom_model.sv
`timescale 1ns/10ps
// record region stand-in; programming can only clear bits
module bbfr_eeprom_model
(
    input  wire        i_clk,
    input  wire [15:0] i_addr,
    input  wire        i_read,
    input  wire        i_prog,
    input  wire [7:0]  i_wdata,
    output reg  [7:0]  o_rdata
);
    reg [7:0] mem [0:127]; // f980 to f9ff
    integer   nprog = 0;   // bytes programmed
    integer   k;

    initial o_rdata = 8'h5a;

    // host erase, every cell back to ones
    task erase;
        begin
            for (k = 0; k < 128; k = k + 1)
                mem[k] = 8'hff;
        end
    endtask

    // data one cycle after the strobe, then it toggles so a late
    // sample cannot pass by luck
    always @(posedge i_clk)
    begin
        if (i_read)
            o_rdata <= mem[i_addr[6:0]];
        else
            o_rdata <= ~o_rdata;
        if (i_prog)
        begin
            mem[i_addr[6:0]] <= mem[i_addr[6:0]] & i_wdata;
            nprog <= nprog + 1;
        end
    end
endmodule // bbfr_eeprom_model

// File: dv/bbfr_recorder_properties.sv
`timescale 1ns/10ps
// pin-level checks of search and record traffic
module bbfr_recorder_checker
#(
    parameter [15:0] BYTE_CYCLES = 16'h0004
)
(
    input wire        i_clk,
    input wire        i_reset,
    input wire        i_recorder_reset,
    input wire        i_record_enter,
    input wire [15:0] o_ee_addr,
    input wire [7:0]  o_ee_wdata,
    input wire        o_ee_read,
    input wire        o_ee_prog,
    input wire        o_busy,
    input wire        o_full
);
    reg [15:0] gap_reg;  // cycles since last program strobe
    reg [15:0] last_reg; // address of last programmed byte

    // gap starts saturated so the first byte is never flagged
    always @(posedge i_clk)
    begin
        if (i_reset)
            gap_reg <= 16'hffff;
        else if (o_ee_prog)
            gap_reg <= 16'h0000;
        else if (gap_reg != 16'hffff)
            gap_reg <= gap_reg + 16'h0001;
        if (o_ee_prog)
            last_reg <= o_ee_addr;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_prog_region: assert property (
        o_ee_prog |-> o_ee_addr[15:7] == 9'h1f3)
        else $error("program outside region");
    a_read_flag: assert property (
        o_ee_read |-> o_ee_addr[15:7] == 9'h1f3 && o_ee_addr[2:0] == 3'h0)
        else $error("search read off flag byte");
    a_byte_spacing: assert property (
        o_ee_prog |-> gap_reg >= BYTE_CYCLES)
        else $error("bytes programmed too close");
    a_prog_busy: assert property (
        o_ee_prog |-> o_busy && !o_ee_read)
        else $error("program while idle");
    a_enter_starts: assert property (
        i_record_enter && !o_busy && !o_full && !i_recorder_reset
        |=> o_ee_prog && o_ee_addr[2:0] == 3'h0)
        else $error("record not started");
    a_flag_cleared: assert property (
        o_ee_prog && o_ee_addr[2:0] == 3'h0 |-> !o_ee_wdata[7])
        else $error("flag not cleared");
    a_full_quiet: assert property (
        o_full && !o_busy |=> !o_ee_prog)
        else $error("program while full");
    a_record_whole: assert property (
        o_ee_prog && o_ee_addr[2:0] != 3'h7 |=> ##[0:200] o_ee_prog)
        else $error("record cut short");
    a_addr_step: assert property (
        o_ee_prog && o_ee_addr[2:0] != 3'h0
        |-> o_ee_addr == last_reg + 16'h0001)
        else $error("byte order broken");

    c_record: cover property (i_record_enter && !o_busy ##1 o_ee_prog);
    c_full: cover property ($rose(o_full));
    c_search: cover property (o_ee_read ##1 !o_ee_read);
endmodule // bbfr_recorder_checker

bind bbfr_recorder bbfr_recorder_checker #(.BYTE_CYCLES(BYTE_CYCLES)) u_chk (
    .i_clk(i_clk), .i_reset(i_reset), .i_recorder_reset(i_recorder_reset),
    .i_record_enter(i_record_enter), .o_ee_addr(o_ee_addr),
    .o_ee_wdata(o_ee_wdata), .o_ee_read(o_ee_read), .o_ee_prog(o_ee_prog),
    .o_busy(o_busy), .o_full(o_full));

// File: dv/tb_black_box_fault_recorder.sv
`timescale 1ns/10ps
module tb_black_box_fault_recorder;
    reg         i_clk = 1'b0;
    reg         i_reset = 1'b1;
    reg         rrst = 1'b0;   // host recorder reset
    reg         ent = 1'b0;    // record state entered
    reg  [7:0]  gpi = 8'h00;   // status snapshot source
    wire [15:0] addr;
    wire [7:0]  wdata, rdata;
    wire        rd, prog, busy, full;
    wire [4:0]  slot;
    integer     num_errors = 0, n_compared = 0, i, k;

    bbfr_recorder #(.BYTE_CYCLES(16'h0004)) DUT (
        .i_clk(i_clk), .i_reset(i_reset), .i_recorder_reset(rrst),
        .i_record_enter(ent), .i_prev_state(gpi[3:0]),
        .i_exit_cause(gpi[1:0] | 2'h1), .i_uv_ov_status({gpi, ~gpi}),
        .i_gpi_status(gpi), .i_limit_status(~gpi), .o_ee_addr(addr),
        .o_ee_wdata(wdata), .o_ee_read(rd), .o_ee_prog(prog),
        .i_ee_rdata(rdata), .o_busy(busy), .o_full(full),
        .o_next_slot(slot));
    bbfr_eeprom_model EE (.i_clk(i_clk), .i_addr(addr), .i_read(rd),
        .i_prog(prog), .i_wdata(wdata), .o_rdata(rdata));

    initial forever #10 i_clk = ~i_clk;

    task close_out;
        begin
            $display("compared %0d errors %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp)
            begin
                num_errors = num_errors + 1;
                $display("Error t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // poll busy until idle, bounded
    task settle;
        begin
            i = 0;
            repeat (2) @(posedge i_clk);
            #1;
            while (busy !== 1'b0 && i < 400)
            begin
                @(posedge i_clk);
                #1;
                i = i + 1;
            end
            if (busy !== 1'b0)
            begin
                num_errors = num_errors + 1;
                close_out;
            end
        end
    endtask

    // one record; dbl retriggers while busy, which must be dropped
    task s_record(input [4:0] s, input [7:0] g, input dbl);
        reg [7:0] sum_exp; // checksum that makes the record sum zero
        begin
            sum_exp = 8'h02 - {4'h0, g[3:0]} - {6'h00, g[1:0] | 2'h1};
            @(posedge i_clk);
            gpi <= g;
            ent <= 1'b1;
            @(posedge i_clk);
            ent <= dbl;
            @(posedge i_clk);
            ent <= 1'b0;
            settle;
            chk(EE.mem[{s[3:0], 3'h4}], g);
            chk(EE.mem[{s[3:0], 3'h5}], g);
            chk(EE.mem[{s[3:0], 3'h6}], 8'hff ^ g);
            chk(EE.mem[{s[3:0], 3'h3}], 8'hff ^ g);
            chk(EE.mem[{s[3:0], 3'h2}], 8'h00);
            chk(EE.mem[{s[3:0], 3'h1}], {14'h0000, g[1:0] | 2'h1});
            chk(EE.mem[{s[3:0], 3'h0}], {12'h000, g[3:0]});
            chk(EE.mem[{s[3:0], 3'h7}], sum_exp);
            if (s < 5'h0f)
            begin
                chk(slot, s + 5'h01);
                chk(EE.mem[{s[3:0] + 4'h1, 3'h0}] >> 7, 16'h0001);
            end
        end
    endtask

    // host recorder reset, search repeats
    task s_rescan(input [4:0] exp_slot, input exp_full);
        begin
            @(posedge i_clk);
            rrst <= 1'b1;
            @(posedge i_clk);
            rrst <= 1'b0;
            settle;
            chk(full, exp_full);
            if (!exp_full)
                chk(slot, exp_slot);
        end
    endtask

    // trigger while full: nothing may be programmed
    task s_full_drop(input [7:0] g);
        begin
            @(posedge i_clk);
            gpi <= g;
            ent <= 1'b1;
            @(posedge i_clk);
            ent <= 1'b0;
            settle;
            chk(EE.nprog[15:0], 16'h0080);
            chk(full, 1'b1);
            chk(slot, 5'h10);
        end
    endtask

    initial
    begin
        EE.erase;
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        settle;
        chk(slot, 5'h00);
        chk(full, 1'b0);
        s_record(5'h00, 8'ha5, 1'b1);
        for (k = 1; k < 16; k = k + 1)
            s_record(k[4:0], k[7:0] * 8'h11, 1'b0);
        chk(full, 1'b1);
        s_full_drop(8'hf0);
        chk(EE.nprog[15:0], 16'h0080);
        EE.erase;
        for (k = 0; k < 5; k = k + 1)
            EE.mem[k * 8] = 8'h00;
        EE.mem[7 * 8] = 8'h00;
        s_rescan(5'h05, 1'b0);
        for (k = 0; k < 16; k = k + 1)
            EE.mem[k * 8] = 8'h00;
        s_rescan(5'h00, 1'b1);
        s_full_drop(8'h3c);
        chk(EE.nprog[15:0], 16'h0080);
        close_out;
    end
endmodule // tb_black_box_fault_recorder
